// >>> lpctl_map.svh
`ifndef LPCTL_MAP_SVH
`define LPCTL_MAP_SVH
`define LPCTL_A_CTRL 3'h0
`define LPCTL_A_STAT 3'h1
`define LPCTL_A_BADR 3'h2
`define LPCTL_A_BCNT 3'h3
`define LPCTL_A_CBUF 3'h4
`define LPCTL_A_TDAT 3'h5
`define LPCTL_A_CSUM 3'h6
`define LPCTL_A_COL  3'h7
`define LPCTL_C_MODE 1:0
`define LPCTL_C_GO   2
`define LPCTL_C_PDIS 3
`define LPCTL_C_TAPE 4
`define LPCTL_C_IEN  5
`define LPCTL_C_RES  6
`define LPCTL_S_FLG  5:1
`define LPCTL_F_DONE 1
`define LPCTL_F_CHI  2
`define LPCTL_F_TPE  3
`define LPCTL_F_MPE  4
`define LPCTL_F_VFE  5
`define LPCTL_TW_RST 13'h1000
`define LPCTL_COLS   8'h84
`define LPCTL_TABW   4'h8
`define LPCTL_CH_HT  8'h09
`define LPCTL_CH_LF  8'h0A
`define LPCTL_CH_FF  8'h0C
`define LPCTL_CH_CR  8'h0D
`define LPCTL_CH_SP  8'h20
`define LPCTL_STEP1  16'h0001
`define LPCTL_STEP2  16'h0002
`endif

// >>> lpctl_pkg.sv
`default_nettype none
package lpctl_pkg;
  typedef enum logic [1:0] {M_TLOAD, M_VLOAD, M_PRINT, M_TEST} lpctl_mode_e;
  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_LOOK, S_OLF, S_TAB, S_SEND, S_HOLD} lpctl_state_e;
  typedef struct packed {
    logic       par;
    logic       paper;
    logic       xlat;
    logic       delim;
    logic       intr;
    logic [7:0] data;
  } lpctl_tword_s;
  typedef struct packed {
    logic [7:0] data;
    logic       par;
    logic       paper;
    logic       vload;
    logic       strobe;
  } lpctl_pr_s;
endpackage : lpctl_pkg
`default_nettype wire

// >>> lpctl_tmem.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_map.svh"
module lpctl_tmem
  import lpctl_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic         we,
  input  wire logic [7:0]   waddr,
  input  wire logic [11:0]  wdata,
  input  wire logic [7:0]   raddr,
  output var lpctl_tword_s  rword,
  output logic              rperr
);
  lpctl_tword_s mem_ff [DEPTH];
  lpctl_tword_s nxt_mem [DEPTH];
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_comb begin
      nxt_mem[i] = mem_ff[i];
      if (we && waddr == 8'(i)) nxt_mem[i] = {~^wdata, wdata};
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) mem_ff[i] <= `LPCTL_TW_RST;
      else mem_ff[i] <= nxt_mem[i];
    end
  end
  assign rword = mem_ff[raddr];
  assign rperr = ~^rword;
  chk_tmem_wr: assert property (@(posedge clk) disable iff (!reset_n)
    we |=> mem_ff[$past(waddr)] == {~^$past(wdata), $past(wdata)})
    else $error("translation word not stored");
endmodule : lpctl_tmem
`default_nettype wire

// >>> lpctl_col.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_map.svh"
module lpctl_col (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        adv,
  input  wire logic        clr,
  output logic [7:0]       col,
  output logic             full,
  output logic [3:0]       tab_n
);
  logic [7:0] col_ff;
  logic [7:0] nxt_col;
  always_comb begin
    nxt_col = col_ff;
    if (clr) nxt_col = 8'h00;
    else if (adv) nxt_col = col_ff + 8'h01;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) col_ff <= 8'h00;
    else col_ff <= nxt_col;
  end
  assign col = col_ff;
  assign full = (col_ff == `LPCTL_COLS);
  assign tab_n = `LPCTL_TABW - {1'b0, col_ff[2:0]};
  chk_tab_stop: assert property (@(posedge clk) disable iff (!reset_n)
    (col_ff[2:0] + tab_n[2:0]) == 3'h0 && tab_n != 4'h0)
    else $error("tab does not reach a stop");
  chk_col_lim: assert property (@(posedge clk) disable iff (!reset_n)
    col_ff <= `LPCTL_COLS)
    else $error("column beyond line length");
endmodule : lpctl_col
`default_nettype wire

// >>> lpctl_top.sv
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_map.svh"
// What this block does
// - checksum plain byte sum, cleared at start
// - hardware tab stops every eight columns
// - force line feed at 133rd character
// - 256-entry memory addressed by character
// - entry holds parity, four controls, data
// - four modes: load, format load, print, test
// - load modes fetch contents from memory
// - test mode simulates printer, sends nothing
// - no format load on tape printers
// - memory and printer parity, printer disableable
// - software writes entry via buffer, data
// - format unit loaded only by DMA
// - address bit 0 picks byte
// - entry controls decide character handling
// - translate bit substitutes entry data
// - paper bit drives paper instruction line on converted chars
// - errors and specials raise interrupt
// - interrupt entry stops, software resumes
// - tab goes to column 9, 17, 25
// - 133rd char starts next line
// - delimiter and next char both converted
module lpctl_top
  import lpctl_pkg::*;
#(
  parameter int AW = 18
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [15:0]   reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic [15:0]        reg_rdata,
  output logic               dma_req,
  output logic [AW-1:0]      dma_addr,
  input  wire logic          dma_ack,
  input  wire logic [15:0]   dma_rdata,
  input  wire logic          dma_perr,
  output var lpctl_pr_s      pr_out,
  input  wire logic          pr_ready,
  output logic               irq
);
  lpctl_state_e  st_ff, nxt_st;
  lpctl_mode_e   mode_ff, nxt_mode;
  logic          pdis_ff, nxt_pdis, tape_ff, nxt_tape, ien_ff, nxt_ien;
  logic          delim_ff, nxt_delim, paper_ff, nxt_paper;
  logic [5:1]    stat_ff, nxt_stat;
  logic [AW-1:0] badr_ff, nxt_badr;
  logic [15:0]   bcnt_ff, nxt_bcnt, rdata_ff, nxt_rdata;
  logic [7:0]    cbuf_ff, nxt_cbuf, csum_ff, nxt_csum, cur_ff, nxt_cur;
  logic [3:0]    tabn_ff, nxt_tabn;
  lpctl_pr_s     pr_ff, nxt_pr;
  lpctl_tword_s  tw;
  logic          rperr, tm_we, col_adv, col_clr, col_full;
  logic [7:0]    tm_wa, col, byt, ch;
  logic [11:0]   tm_wd;
  logic [3:0]    tab_n;
  logic          send_ok, is_test, wr_ctl, go, xl, ctl_ch;

  lpctl_tmem u_tmem (
    .clk     (clk),
    .reset_n (reset_n),
    .we      (tm_we),
    .waddr   (tm_wa),
    .wdata   (tm_wd),
    .raddr   (cbuf_ff),
    .rword   (tw),
    .rperr   (rperr)
  );

  lpctl_col u_col (
    .clk     (clk),
    .reset_n (reset_n),
    .adv     (col_adv),
    .clr     (col_clr),
    .col     (col),
    .full    (col_full),
    .tab_n   (tab_n)
  );

  // printer word with parity; a disabled generator drives the bit low
  function automatic lpctl_pr_s mk_pr(input logic [7:0] d, input logic pp,
                                      input logic vl, input logic stb, input logic dis);
    mk_pr.data   = d;
    mk_pr.par    = dis ? 1'b0 : ~^d;
    mk_pr.paper  = pp;
    mk_pr.vload  = vl;
    mk_pr.strobe = stb;
  endfunction : mk_pr

  // test mode answers for the printer itself
  assign is_test = (mode_ff == M_TEST);
  assign send_ok = is_test || pr_ready;
  // address bit 0 selects the byte
  assign byt     = badr_ff[0] ? dma_rdata[15:8] : dma_rdata[7:0];
  assign wr_ctl  = reg_wr && reg_addr == `LPCTL_A_CTRL;
  assign go      = wr_ctl && reg_wdata[`LPCTL_C_GO];
  // a character after a delimiter is always converted
  assign xl      = tw.xlat || tw.delim || delim_ff;
  // translated data replaces the buffered code
  assign ch      = xl ? tw.data : cbuf_ff;
  assign ctl_ch  = cur_ff == `LPCTL_CH_LF || cur_ff == `LPCTL_CH_FF ||
                   cur_ff == `LPCTL_CH_CR;
  assign dma_req  = (st_ff == S_FETCH);
  assign dma_addr = badr_ff;
  assign pr_out   = pr_ff;
  assign reg_rdata = rdata_ff;
  // any pending flag raises the interrupt
  assign irq      = ien_ff && |stat_ff;

  always_comb begin
    nxt_st    = st_ff;
    nxt_mode  = mode_ff;
    nxt_pdis  = pdis_ff;
    nxt_tape  = tape_ff;
    nxt_ien   = ien_ff;
    nxt_delim = delim_ff;
    nxt_paper = paper_ff;
    nxt_stat  = stat_ff;
    nxt_badr  = badr_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_cbuf  = cbuf_ff;
    nxt_csum  = csum_ff;
    nxt_cur   = cur_ff;
    nxt_tabn  = tabn_ff;
    nxt_pr    = mk_pr(pr_ff.data, pr_ff.paper, pr_ff.vload, 1'b0, pdis_ff);
    nxt_rdata = 16'h0000;
    tm_we     = 1'b0;
    tm_wa     = cbuf_ff;
    tm_wd     = reg_wdata[11:0];
    col_adv   = 1'b0;
    col_clr   = 1'b0;
    // software clears flags by writing ones; a same-cycle event still sets
    if (reg_wr && reg_addr == `LPCTL_A_STAT)
      nxt_stat = stat_ff & ~reg_wdata[`LPCTL_S_FLG];
    if (st_ff == S_IDLE) begin
      if (wr_ctl) begin
        nxt_mode = lpctl_mode_e'(reg_wdata[`LPCTL_C_MODE]);
        nxt_pdis = reg_wdata[`LPCTL_C_PDIS];
        nxt_tape = reg_wdata[`LPCTL_C_TAPE];
        nxt_ien  = reg_wdata[`LPCTL_C_IEN];
      end
      if (reg_wr && reg_addr == `LPCTL_A_BADR) nxt_badr = AW'(reg_wdata);
      if (reg_wr && reg_addr == `LPCTL_A_BCNT) nxt_bcnt = reg_wdata;
    end else if (wr_ctl) begin
      nxt_ien = reg_wdata[`LPCTL_C_IEN];
    end
    if (reg_wr && reg_addr == `LPCTL_A_CBUF) nxt_cbuf = reg_wdata[7:0];
    // program write of one entry at the buffered address
    if (reg_wr && reg_addr == `LPCTL_A_TDAT) tm_we = 1'b1;
    unique case (st_ff)
      S_IDLE: begin
        if (go) begin
          nxt_csum  = 8'h00;
          nxt_delim = 1'b0;
          if (bcnt_ff == 16'h0000) nxt_stat[`LPCTL_F_DONE] = 1'b1;
          else nxt_st = S_FETCH;
        end
      end
      S_FETCH: begin
        if (dma_ack) begin
          if (dma_perr) begin
            // main memory parity error ends the transfer
            nxt_stat[`LPCTL_F_MPE] = 1'b1;
            nxt_st = S_IDLE;
          end else if (mode_ff == M_TLOAD) begin
            tm_we    = 1'b1;
            tm_wd    = dma_rdata[11:0];
            nxt_cbuf = cbuf_ff + 8'h01;
            nxt_csum = csum_ff + dma_rdata[7:0] + dma_rdata[15:8];
            nxt_badr = badr_ff + AW'(`LPCTL_STEP2);
            nxt_bcnt = (bcnt_ff > `LPCTL_STEP2) ? bcnt_ff - `LPCTL_STEP2 : 16'h0000;
            if (bcnt_ff <= `LPCTL_STEP2) begin
              nxt_stat[`LPCTL_F_DONE] = 1'b1;
              nxt_st = S_IDLE;
            end
          end else begin
            nxt_csum = csum_ff + byt;
            nxt_badr = badr_ff + AW'(`LPCTL_STEP1);
            nxt_bcnt = bcnt_ff - `LPCTL_STEP1;
            if (mode_ff == M_VLOAD) begin
              nxt_cur   = byt;
              nxt_paper = 1'b0;
              // tape format units are never loaded
              if (tape_ff) begin
                nxt_stat[`LPCTL_F_VFE] = 1'b1;
                nxt_st = S_IDLE;
              end else begin
                nxt_st = S_SEND;
              end
            end else begin
              // the selected byte enters the buffer
              nxt_cbuf = byt;
              nxt_st   = S_LOOK;
            end
          end
        end
      end
      S_LOOK: begin
        nxt_cur   = ch;
        // paper bit counts only with translation
        nxt_paper = xl && tw.paper;
        nxt_delim = tw.delim && !delim_ff;
        nxt_tabn  = tab_n;
        if (rperr) begin
          nxt_stat[`LPCTL_F_TPE] = 1'b1;
          nxt_st = S_IDLE;
        end else if (tw.intr && !delim_ff) begin
          // flag the character and wait for software
          nxt_stat[`LPCTL_F_CHI] = 1'b1;
          nxt_st = S_HOLD;
        end else if (!xl && cbuf_ff == `LPCTL_CH_HT) begin
          nxt_st = S_TAB;
        end else if (!(xl && tw.paper) && col_full) begin
          nxt_st = S_OLF;
        end else begin
          nxt_st = S_SEND;
        end
      end
      S_OLF: begin
        if (send_ok) begin
          // forced line feed before the 133rd character
          nxt_pr  = mk_pr(`LPCTL_CH_LF, 1'b0, 1'b0, !is_test, pdis_ff);
          col_clr = 1'b1;
          // held character then opens the new line
          nxt_st  = S_SEND;
        end
      end
      S_TAB: begin
        if (send_ok) begin
          col_adv  = !col_full;
          col_clr  = col_full;
          nxt_tabn = tabn_ff - 4'h1;
          nxt_pr   = mk_pr(col_full ? `LPCTL_CH_LF : `LPCTL_CH_SP, 1'b0, 1'b0,
                           !is_test, pdis_ff);
          if (tabn_ff == 4'h1 || col_full)
            nxt_st = (bcnt_ff == 16'h0000) ? S_IDLE : S_FETCH;
          if ((tabn_ff == 4'h1 || col_full) && bcnt_ff == 16'h0000)
            nxt_stat[`LPCTL_F_DONE] = 1'b1;
        end
      end
      S_SEND: begin
        if (send_ok) begin
          // format data goes out only from the format load mode
          nxt_pr = mk_pr(cur_ff, paper_ff, mode_ff == M_VLOAD, !is_test, pdis_ff);
          if (mode_ff != M_VLOAD) begin
            col_clr = paper_ff || ctl_ch;
            col_adv = !(paper_ff || ctl_ch);
          end
          nxt_st = (bcnt_ff == 16'h0000) ? S_IDLE : S_FETCH;
          if (bcnt_ff == 16'h0000) nxt_stat[`LPCTL_F_DONE] = 1'b1;
        end
      end
      S_HOLD: begin
        if (wr_ctl && reg_wdata[`LPCTL_C_RES]) begin
          nxt_st = (bcnt_ff == 16'h0000) ? S_IDLE : S_FETCH;
          if (bcnt_ff == 16'h0000) nxt_stat[`LPCTL_F_DONE] = 1'b1;
        end
      end
    endcase
    if (reg_rd) begin
      unique case (reg_addr)
        `LPCTL_A_CTRL: nxt_rdata = {9'h000, ien_ff, ien_ff, tape_ff, pdis_ff,
                                    1'b0, mode_ff};
        `LPCTL_A_STAT: nxt_rdata = {10'h000, stat_ff, st_ff != S_IDLE};
        `LPCTL_A_BADR: nxt_rdata = 16'(badr_ff);
        `LPCTL_A_BCNT: nxt_rdata = bcnt_ff;
        `LPCTL_A_CBUF: nxt_rdata = {8'h00, cbuf_ff};
        `LPCTL_A_TDAT: nxt_rdata = {3'h0, tw};
        `LPCTL_A_CSUM: nxt_rdata = {8'h00, csum_ff};
        `LPCTL_A_COL:  nxt_rdata = {8'h00, col};
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff    <= S_IDLE;
      mode_ff  <= M_PRINT;
      pdis_ff  <= 1'b0;
      tape_ff  <= 1'b0;
      ien_ff   <= 1'b0;
      delim_ff <= 1'b0;
      paper_ff <= 1'b0;
      stat_ff  <= 5'h00;
      badr_ff  <= '0;
      bcnt_ff  <= 16'h0000;
      cbuf_ff  <= 8'h00;
      csum_ff  <= 8'h00;
      cur_ff   <= 8'h00;
      tabn_ff  <= 4'h0;
      pr_ff    <= '0;
      rdata_ff <= 16'h0000;
    end else begin
      st_ff    <= nxt_st;
      mode_ff  <= nxt_mode;
      pdis_ff  <= nxt_pdis;
      tape_ff  <= nxt_tape;
      ien_ff   <= nxt_ien;
      delim_ff <= nxt_delim;
      paper_ff <= nxt_paper;
      stat_ff  <= nxt_stat;
      badr_ff  <= nxt_badr;
      bcnt_ff  <= nxt_bcnt;
      cbuf_ff  <= nxt_cbuf;
      csum_ff  <= nxt_csum;
      cur_ff   <= nxt_cur;
      tabn_ff  <= nxt_tabn;
      pr_ff    <= nxt_pr;
      rdata_ff <= nxt_rdata;
    end
  end

  sequence s_delim_hit;
    st_ff == S_LOOK && !rperr && tw.delim && !delim_ff && !tw.intr;
  endsequence
  sequence s_byte_in;
    st_ff == S_FETCH && dma_ack && !dma_perr && mode_ff inside {M_PRINT, M_TEST};
  endsequence

  chk_cksum_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (go && st_ff == S_IDLE) |=> csum_ff == 8'h00)
    else $error("checksum not cleared at start");
  chk_byte_pick: assert property (@(posedge clk) disable iff (!reset_n)
    s_byte_in |=> cbuf_ff == ($past(badr_ff[0]) ? $past(dma_rdata[15:8])
                                                : $past(dma_rdata[7:0])))
    else $error("wrong byte taken");
  chk_ovf_lf: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == S_OLF && pr_ready && !is_test) |=>
      pr_out.strobe && pr_out.data == `LPCTL_CH_LF && st_ff == S_SEND)
    else $error("overflow line feed missing");
  chk_test_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    (is_test && $past(is_test)) |-> !pr_out.strobe)
    else $error("printer strobed in test mode");
  chk_vfu_tape: assert property (@(posedge clk) disable iff (!reset_n)
    (tape_ff && $past(tape_ff)) |-> !(pr_out.strobe && pr_out.vload))
    else $error("format load sent to tape unit");
  chk_paper_line: assert property (@(posedge clk) disable iff (!reset_n)
    (st_ff == S_SEND && pr_ready && paper_ff && !is_test) |=>
      pr_out.strobe && pr_out.paper)
    else $error("paper line not asserted");
  chk_pr_parity: assert property (@(posedge clk) disable iff (!reset_n)
    (pr_out.strobe && !pdis_ff && !$past(pdis_ff)) |-> pr_out.par == ~^pr_out.data)
    else $error("printer parity wrong");
  chk_delim_next: assert property (@(posedge clk) disable iff (!reset_n)
    s_delim_hit |=> delim_ff)
    else $error("delimiter not remembered");
endmodule : lpctl_top
`default_nettype wire

// >>> lpctl_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lpctl_host_model #(
  parameter int AW = 18
) (
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          dma_req,
  input  wire logic [AW-1:0] dma_addr,
  input  wire logic [3:0]    lat,
  input  wire logic [AW-1:0] perr_addr,
  output logic               dma_ack,
  output logic [15:0]        dma_rdata,
  output logic               dma_perr
);
  logic [15:0] mem [0:511];
  logic [3:0]  wait_cnt;

  // whole words go out, the controller picks the byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dma_ack   <= 1'b0;
      dma_perr  <= 1'b0;
      dma_rdata <= 16'hA5C3;
      wait_cnt  <= 4'h0;
    end else begin
      dma_ack  <= 1'b0;
      dma_perr <= 1'b0;
      if (dma_ack) begin
        // bus released: stale data must not look valid, so show its inverse
        dma_rdata <= ~dma_rdata;
      end else if (dma_req && wait_cnt >= lat) begin
        dma_ack   <= 1'b1;
        dma_rdata <= mem[dma_addr[9:1]];
        dma_perr  <= (dma_addr == perr_addr);
        wait_cnt  <= 4'h0;
      end else if (dma_req) begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : lpctl_host_model
`default_nettype wire

// >>> lpctl_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "lpctl_map.svh"
module lpctl_top_test
  import lpctl_pkg::*;
;
  localparam int AW = 18;
  localparam logic [7:0]  TA [5] = '{8'h41, 8'h50, 8'h5C, 8'h43, 8'h7F};
  localparam logic [11:0] TW [5] = '{12'h461, 12'hC0C, 12'h223, 12'h02B, 12'h17F};
  logic          clk;
  logic          reset_n   = 1'b0;
  logic          reg_wr    = 1'b0;
  logic          reg_rd    = 1'b0;
  logic [2:0]    reg_addr  = 3'h0;
  logic [15:0]   reg_wdata = 16'h0000;
  logic [15:0]   reg_rdata;
  logic          dma_req;
  logic          dma_ack;
  logic          dma_perr;
  logic [15:0]   dma_rdata;
  logic [AW-1:0] dma_addr;
  logic [AW-1:0] perr_addr = '1;
  logic          pr_ready  = 1'b0;
  logic [3:0]    lat       = 4'h0;
  logic          irq;
  lpctl_pr_s     pr_out;
  logic [15:0]   rd_val;
  logic [7:0]    sum;
  logic [7:0]    bq [$];
  logic [10:0]   exp_q [$];
  logic [10:0]   got;
  logic [15:0]   seen_pr;
  int            bad_count = 0;
  int            samples_checked = 0;
  int            cycles = 0;
  integer        seed = 32'hEBB3;

  lpctl_top #(.AW(AW)) u_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_req(dma_req),
    .dma_addr(dma_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .dma_perr(dma_perr), .pr_out(pr_out), .pr_ready(pr_ready), .irq(irq)
  );
  lpctl_host_model #(.AW(AW)) u_host (
    .clk(clk), .reset_n(reset_n), .dma_req(dma_req), .dma_addr(dma_addr),
    .lat(lat), .perr_addr(perr_addr), .dma_ack(dma_ack), .dma_rdata(dma_rdata),
    .dma_perr(dma_perr)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // printer stalls and memory latency vary every cycle
  always @(posedge clk) begin
    pr_ready <= 1'($random(seed));
    lat      <= 4'($random(seed)) & 4'h7;
    cycles++;
    if (cycles > 60000) begin
      bad_count++;
      end_sim();
    end
  end

  always @(posedge clk) begin
    if (reset_n && pr_out.strobe === 1'b1) begin
      if (exp_q.size() == 0) check("stray strobe", 16'h0001, 16'h0000);
      else begin
        got = exp_q.pop_front();
        seen_pr = {5'h00, pr_out.vload, pr_out.data, pr_out.par, pr_out.paper};
        check("printer char", seen_pr, {5'h00, got});
      end
    end
  end

  task automatic ex(input logic [7:0] d, input logic pp = 1'b0, input logic np = 1'b0,
                    input logic vl = 1'b0);
    exp_q.push_back({vl, d, np ? 1'b0 : ~^d, pp});
  endtask : ex

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  task automatic putq(input logic [9:0] a, input logic [7:0] b [$]);
    sum = 8'h00;
    foreach (b[i]) begin
      if (a[0]) u_host.mem[a[9:1]][15:8] = b[i];
      else u_host.mem[a[9:1]][7:0] = b[i];
      sum = sum + b[i];
      a = a + 10'h001;
    end
  endtask : putq

  task automatic go(input logic [15:0] ctl, input logic [15:0] a, input logic [15:0] n);
    wr(`LPCTL_A_BADR, a);
    wr(`LPCTL_A_BCNT, n);
    wr(`LPCTL_A_CTRL, ctl | 16'h0004);
  endtask : go

  task automatic run(input logic [15:0] ctl, input logic [15:0] a, input logic [15:0] n);
    go(ctl, a, n);
    for (int i = 0; i < 3000; i++) begin
      rd(`LPCTL_A_STAT);
      if (rd_val[0] === 1'b0) break;
    end
    check("busy clear", rd_val & 16'h0001, 16'h0000);
    check("chars left", 16'(exp_q.size()), 16'h0000);
  endtask : run

  task automatic csum_is(input logic [7:0] e);
    rd(`LPCTL_A_CSUM);
    check("checksum", rd_val & 16'h00FF, {8'h00, e});
  endtask : csum_is

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    rd(`LPCTL_A_CTRL);
    check("ctrl reset", rd_val, 16'h0002);
    wr(`LPCTL_A_CBUF, 16'h0033);
    rd(`LPCTL_A_TDAT);
    check("entry reset", rd_val, 16'h1000);
    foreach (TA[i]) begin
      wr(`LPCTL_A_CBUF, {8'h00, TA[i]});
      wr(`LPCTL_A_TDAT, {4'h0, TW[i]});
      rd(`LPCTL_A_TDAT);
      check("entry word", rd_val, {3'h0, ~^TW[i], TW[i]});
    end
    // translate, paper, delimiter pair, odd start byte
    putq(10'h101, '{8'h41, 8'h42, 8'h50, 8'h5C, 8'h43, 8'h43});
    ex(8'h61);
    ex(8'h42);
    ex(8'h0C, 1'b1);
    ex(8'h23);
    ex(8'h2B);
    ex(8'h43);
    run(16'h0002, 16'h0101, 16'h0006);
    csum_is(sum);
    // tab from column 1 and from column 10
    putq(10'h120, '{8'h0D, 8'h09, 8'h42, 8'h09});
    ex(8'h0D);
    repeat (8) ex(8'h20);
    ex(8'h42);
    repeat (7) ex(8'h20);
    run(16'h0002, 16'h0120, 16'h0004);
    rd(`LPCTL_A_COL);
    check("column", rd_val, 16'h0010);
    // overflow line feed then the held character
    bq = '{8'h0D};
    repeat (133) bq.push_back(8'h42);
    putq(10'h140, bq);
    ex(8'h0D);
    repeat (132) ex(8'h42);
    ex(8'h0A);
    ex(8'h42);
    run(16'h0002, 16'h0140, 16'h0086);
    // test mode sends nothing, checksum restarts
    putq(10'h1D0, '{8'h0D, 8'h41});
    run(16'h0003, 16'h01D0, 16'h0002);
    csum_is(8'h4E);
    putq(10'h1D4, '{8'h0D, 8'h42});
    ex(8'h0D, 1'b0, 1'b1);
    ex(8'h42, 1'b0, 1'b1);
    run(16'h000A, 16'h01D4, 16'h0002);
    wr(`LPCTL_A_STAT, 16'h003E);
    putq(10'h1E0, '{8'h0D, 8'h7F, 8'h42});
    ex(8'h0D);
    go(16'h0022, 16'h01E0, 16'h0003);
    for (int i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
    check("irq raised", 16'(irq), 16'h0001);
    rd(`LPCTL_A_STAT);
    check("char flag", rd_val & 16'h0006, 16'h0004);
    wr(`LPCTL_A_STAT, 16'h0004);
    @(posedge clk);
    check("irq cleared", 16'(irq), 16'h0000);
    ex(8'h42);
    run(16'h0060, 16'h01E0, 16'h0003);
    rd(`LPCTL_A_STAT);
    check("done flag", rd_val & 16'h0002, 16'h0002);
    check("irq on done", 16'(irq), 16'h0001);
    wr(`LPCTL_A_STAT, 16'h003E);
    wr(`LPCTL_A_CTRL, 16'h0002);
    // memory parity error stops the transfer
    putq(10'h1F0, '{8'h42});
    perr_addr <= 18'h001F0;
    run(16'h0002, 16'h01F0, 16'h0001);
    rd(`LPCTL_A_STAT);
    check("mem parity flag", rd_val & 16'h0010, 16'h0010);
    perr_addr <= '1;
    wr(`LPCTL_A_STAT, 16'h003E);
    // format load refused on a tape unit
    run(16'h0011, 16'h01F0, 16'h0002);
    rd(`LPCTL_A_STAT);
    check("tape refusal", rd_val & 16'h0020, 16'h0020);
    check("irq masked", 16'(irq), 16'h0000);
    wr(`LPCTL_A_STAT, 16'h003E);
    // twelve channels per line as two bytes
    // line 1 holds channel 1, line 2 channel 12
    putq(10'h1F4, '{8'h01, 8'h00, 8'h00, 8'h08});
    ex(8'h01, 1'b0, 1'b0, 1'b1);
    ex(8'h00, 1'b0, 1'b0, 1'b1);
    ex(8'h00, 1'b0, 1'b0, 1'b1);
    ex(8'h08, 1'b0, 1'b0, 1'b1);
    run(16'h0001, 16'h01F4, 16'h0004);
    rd(`LPCTL_A_STAT);
    check("format load done", rd_val & 16'h0022, 16'h0002);
    wr(`LPCTL_A_STAT, 16'h003E);
    u_host.mem[9'h180] = 16'h04A5;
    u_host.mem[9'h181] = 16'h080C;
    wr(`LPCTL_A_CBUF, 16'h0090);
    run(16'h0000, 16'h0300, 16'h0004);
    csum_is(8'hA5 + 8'h04 + 8'h0C + 8'h08);
    wr(`LPCTL_A_CBUF, 16'h0090);
    rd(`LPCTL_A_TDAT);
    check("dma entry 0", rd_val, {3'h0, ~^12'h4A5, 12'h4A5});
    wr(`LPCTL_A_CBUF, 16'h0091);
    rd(`LPCTL_A_TDAT);
    check("dma entry 1", rd_val, {3'h0, ~^12'h80C, 12'h80C});
    end_sim();
  end
endmodule : lpctl_top_test
`default_nettype wire
